// >>> hdg_pkg.sv
// hub descriptor generator: shared constants and types
// assumes byte-wide descriptor stream, single core clock domain
package hdg_pkg;

   // ========================================================
   // stream shape
   // ========================================================
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int IDX_W = 4;
   localparam int VEC_W = 72;

   // ========================================================
   // descriptor kinds a request can ask for
   // ========================================================
   typedef enum logic [1:0] {
      KIND_EP_STATUS = 2'h0,
      KIND_IF_SINGLE = 2'h1,
      KIND_IF_MULTI = 2'h2,
      KIND_OTHER_CFG = 2'h3
   } hdg_kind_e;

   // ========================================================
   // status-change endpoint descriptor
   // ========================================================
   localparam logic [7:0] EP_LEN = 8'h07;
   localparam logic [7:0] EP_TYPE = 8'h05;
   localparam logic [7:0] EP_ADDR = 8'h81;
   localparam logic [7:0] EP_ATTR = 8'h03;
   localparam logic [15:0] EP_MAX_PKT = 16'h0001;
   localparam logic [7:0] EP_INTERVAL = 8'h0C;

   // ========================================================
   // high-speed interface descriptor
   // ========================================================
   localparam logic [7:0] IF_LEN = 8'h09;
   localparam logic [7:0] IF_TYPE = 8'h04;
   localparam logic [7:0] IF_NUMBER = 8'h00;
   localparam logic [7:0] IF_ALT_SINGLE = 8'h00;
   localparam logic [7:0] IF_ALT_MULTI = 8'h01;
   localparam logic [7:0] IF_NUM_EP = 8'h01;
   localparam logic [7:0] IF_CLASS_HUB = 8'h09;
   localparam logic [7:0] IF_SUBCLASS = 8'h00;
   localparam logic [7:0] IF_PROTO_SINGLE = 8'h01;
   localparam logic [7:0] IF_PROTO_MULTI = 8'h02;
   localparam logic [7:0] STR_IDX_NONE = 8'h00;

   // ========================================================
   // other-speed configuration descriptor
   // ========================================================
   localparam logic [7:0] OSC_LEN = 8'h09;
   localparam logic [7:0] OSC_TYPE = 8'h07;
   localparam logic [15:0] OSC_TOTAL_LEN = 16'h0019;
   localparam logic [7:0] OSC_NUM_IF = 8'h01;
   localparam logic [7:0] OSC_CFG_VALUE = 8'h01;
   localparam logic [7:0] ATTR_BUS_PWR = 8'hA0;
   localparam logic [7:0] ATTR_SELF_PWR = 8'hE0;
   localparam int ATTR_REMOTE_WAKE_BIT = 5;

   // ========================================================
   // reset values
   // ========================================================
   localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// >>> hdg_fifo.sv
// hub descriptor generator: byte fifo between generator and output stage
// assumes one clock, synchronous active-high reset, depth a power of two
`timescale 1ns/1ps
module hdg_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = cnt_q != CNT_FULL;
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage needs no reset; only words below the count are ever read
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

endmodule

// >>> hdg_gen.sv
// hub descriptor generator: streams standard hub descriptor bytes
// assumes power settings come from configuration logic on ref_clk,
// and the consumer pulls bytes with a valid/ready handshake
//
// Operation
// - endpoint: length 07h, type 05h, address 81h
// - endpoint attributes 03h, interrupt, no sync
// - endpoint max packet size 0001h
// - endpoint polling interval 0Ch, both modes
// - multi-TT interface: 09h, 04h, 00h, alt 01h
// - one endpoint, hub class 09h, subclass 00h
// - multi-TT interface protocol 02h
// - all string index fields read 00h
// - other-speed config: length 09h, type 07h
// - other-speed total length 0019h
// - one interface, configuration value 01h
// - attributes A0h bus-powered, E0h self-powered
// - attributes always advertise remote wakeup
// - max power in 2mA units per mode
// - max power from stored current limits
// - single-TT interface: alt 00h, protocol 01h
`timescale 1ns/1ps
module hdg_gen #(
   parameter int FIFO_DEPTH = hdg_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // loaded hub configuration
   input wire logic power_source_select,
   input wire logic [7:0] bus_powered_current_limit,
   input wire logic [7:0] self_powered_current_limit,
   // descriptor request
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   input wire logic [7:0] req_len,
   output logic req_ready_q,
   output logic done_q,
   // descriptor byte stream
   output logic out_valid_q,
   output logic [7:0] out_data_q,
   output logic out_last_q,
   input wire logic out_ready
);
   localparam int IW = hdg_pkg::IDX_W;
   localparam int VW = hdg_pkg::VEC_W;
   localparam int FW = hdg_pkg::BYTE_W + 1;

   // ========================================================
   // control state
   // ========================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EMIT = 2'b10
   } hdg_state_e;

   hdg_state_e state_q, state_d;
   hdg_pkg::hdg_kind_e kind_q, kind_d;
   logic [IW-1:0] idx_q, idx_d;
   logic [IW-1:0] count_q, count_d;
   logic pwr_sel_q, pwr_sel_d;
   logic [7:0] bp_lim_q, bp_lim_d;
   logic [7:0] sp_lim_q, sp_lim_d;
   logic req_ready_d;
   logic done_d;

   // ========================================================
   // descriptor images, byte 0 in the low bits
   // ========================================================
   // no descriptor here is longer than nine bytes, so one 72-bit image
   // serves every kind; the endpoint image pads its top bytes with zero
   logic [VW-1:0] ep_vec;
   logic [VW-1:0] if_vec;
   logic [VW-1:0] cfg_vec;
   logic [VW-1:0] sel_vec;
   logic [7:0] cfg_attr;
   logic [7:0] cfg_power;
   logic [7:0] cur_byte;
   logic [IW-1:0] req_desc_len;
   logic [IW-1:0] req_count;
   logic [7:0] req_desc_len8;

   // both power encodings carry the remote-wakeup bit, so a select
   // between the two fixed values keeps it set in either mode
   assign cfg_attr = pwr_sel_q ? hdg_pkg::ATTR_SELF_PWR
                               : hdg_pkg::ATTR_BUS_PWR;
   assign cfg_power = pwr_sel_q ? sp_lim_q : bp_lim_q;

   // concatenation lists fields from highest offset down
   assign ep_vec = {16'h0000,
                    hdg_pkg::EP_INTERVAL,
                    hdg_pkg::EP_MAX_PKT[15:8],
                    hdg_pkg::EP_MAX_PKT[7:0],
                    hdg_pkg::EP_ATTR,
                    hdg_pkg::EP_ADDR,
                    hdg_pkg::EP_TYPE,
                    hdg_pkg::EP_LEN};

   always_comb begin
      if (kind_q == hdg_pkg::KIND_IF_MULTI) begin
         if_vec = {hdg_pkg::STR_IDX_NONE,
                   hdg_pkg::IF_PROTO_MULTI,
                   hdg_pkg::IF_SUBCLASS,
                   hdg_pkg::IF_CLASS_HUB,
                   hdg_pkg::IF_NUM_EP,
                   hdg_pkg::IF_ALT_MULTI,
                   hdg_pkg::IF_NUMBER,
                   hdg_pkg::IF_TYPE,
                   hdg_pkg::IF_LEN};
      end else begin
         if_vec = {hdg_pkg::STR_IDX_NONE,
                   hdg_pkg::IF_PROTO_SINGLE,
                   hdg_pkg::IF_SUBCLASS,
                   hdg_pkg::IF_CLASS_HUB,
                   hdg_pkg::IF_NUM_EP,
                   hdg_pkg::IF_ALT_SINGLE,
                   hdg_pkg::IF_NUMBER,
                   hdg_pkg::IF_TYPE,
                   hdg_pkg::IF_LEN};
      end
   end

   assign cfg_vec = {cfg_power,
                     cfg_attr,
                     hdg_pkg::STR_IDX_NONE,
                     hdg_pkg::OSC_CFG_VALUE,
                     hdg_pkg::OSC_NUM_IF,
                     hdg_pkg::OSC_TOTAL_LEN[15:8],
                     hdg_pkg::OSC_TOTAL_LEN[7:0],
                     hdg_pkg::OSC_TYPE,
                     hdg_pkg::OSC_LEN};

   always_comb begin
      case (kind_q)
         hdg_pkg::KIND_EP_STATUS: sel_vec = ep_vec;
         hdg_pkg::KIND_IF_SINGLE: sel_vec = if_vec;
         hdg_pkg::KIND_IF_MULTI: sel_vec = if_vec;
         hdg_pkg::KIND_OTHER_CFG: sel_vec = cfg_vec;
         default: sel_vec = ep_vec;
      endcase
   end

   assign cur_byte = sel_vec[{idx_q, 3'b000} +: 8];

   // ========================================================
   // request sizing: the host may ask for fewer bytes
   // ========================================================
   // a short request ends early: the last flag follows the cut count,
   // not the descriptor's own length byte
   always_comb begin
      case (req_kind)
         hdg_pkg::KIND_EP_STATUS: req_desc_len8 = hdg_pkg::EP_LEN;
         hdg_pkg::KIND_IF_SINGLE: req_desc_len8 = hdg_pkg::IF_LEN;
         hdg_pkg::KIND_IF_MULTI: req_desc_len8 = hdg_pkg::IF_LEN;
         hdg_pkg::KIND_OTHER_CFG: req_desc_len8 = hdg_pkg::OSC_LEN;
         default: req_desc_len8 = hdg_pkg::EP_LEN;
      endcase
   end

   assign req_desc_len = req_desc_len8[IW-1:0];
   assign req_count = (req_len < req_desc_len8) ? req_len[IW-1:0] : req_desc_len;

   // ========================================================
   // byte fifo
   // ========================================================
   // fifo plus output register hold a whole nine-byte descriptor, so a
   // paused host never parks the generator in the middle of a request;
   // only a second request behind an undrained one has to wait
   logic push_valid;
   logic push_ready;
   logic push_last;
   logic pop_valid;
   logic pop_ready;
   logic [FW-1:0] pop_data;

   assign push_valid = state_q == ST_EMIT;
   assign push_last = idx_q == count_q - 1'b1;

   hdg_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_data({push_last, cur_byte}),
      .in_ready(push_ready),
      .out_valid(pop_valid),
      .out_data(pop_data),
      .out_ready(pop_ready)
   );

   // ========================================================
   // generator sequence
   // ========================================================
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      idx_d = idx_q;
      count_d = count_q;
      pwr_sel_d = pwr_sel_q;
      bp_lim_d = bp_lim_q;
      sp_lim_d = sp_lim_q;
      done_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (req_valid && req_ready_q) begin
               // settings are frozen per request so one descriptor
               // never mixes bytes from two power modes
               kind_d = hdg_pkg::hdg_kind_e'(req_kind);
               pwr_sel_d = power_source_select;
               bp_lim_d = bus_powered_current_limit;
               sp_lim_d = self_powered_current_limit;
               idx_d = hdg_pkg::IDX_RST;
               count_d = req_count;
               // zero-length request: done at once, nothing is pushed
               if (req_count == '0) begin
                  done_d = 1'b1;
               end else begin
                  state_d = ST_EMIT;
               end
            end
         end
         ST_EMIT: begin
            // the offset only moves on an accepted push, so a full
            // fifo keeps the generator waiting on the same byte
            if (push_ready) begin
               idx_d = idx_q + 1'b1;
               if (push_last) begin
                  state_d = ST_IDLE;
                  done_d = 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      req_ready_d = state_d == ST_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         kind_q <= hdg_pkg::KIND_EP_STATUS;
         idx_q <= hdg_pkg::IDX_RST;
         count_q <= hdg_pkg::IDX_RST;
         pwr_sel_q <= 1'b0;
         bp_lim_q <= hdg_pkg::BYTE_RST;
         sp_lim_q <= hdg_pkg::BYTE_RST;
         req_ready_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         idx_q <= idx_d;
         count_q <= count_d;
         pwr_sel_q <= pwr_sel_d;
         bp_lim_q <= bp_lim_d;
         sp_lim_q <= sp_lim_d;
         req_ready_q <= req_ready_d;
         done_q <= done_d;
      end
   end

   // ========================================================
   // output register stage
   // ========================================================
   // done_q marks the last byte entering the fifo, not leaving it;
   // the consumer should use out_last_q to end its transfer
   logic out_valid_d;
   logic out_last_d;
   logic [7:0] out_data_d;

   // refill whenever the register is empty or its byte is being taken
   assign pop_ready = !out_valid_q || out_ready;

   always_comb begin
      out_valid_d = out_valid_q;
      out_data_d = out_data_q;
      out_last_d = out_last_q;
      if (pop_ready) begin
         out_valid_d = pop_valid;
         if (pop_valid) begin
            out_data_d = pop_data[7:0];
            out_last_d = pop_data[8];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_valid_q <= 1'b0;
         out_data_q <= hdg_pkg::BYTE_RST;
         out_last_q <= 1'b0;
      end else begin
         out_valid_q <= out_valid_d;
         out_data_q <= out_data_d;
         out_last_q <= out_last_d;
      end
   end

endmodule

// >>> hdg_gen_asserts.sv
// hub descriptor generator: concurrent checks on the top ports
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module hdg_gen_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // request
   input wire logic req_valid,
   input wire logic [7:0] req_len,
   input wire logic req_ready_q,
   input wire logic done_q,
   // byte stream
   input wire logic out_valid_q,
   input wire logic [7:0] out_data_q,
   input wire logic out_last_q,
   input wire logic out_ready
);
   // ========================================================
   // byte offset within the descriptor now on the stream
   // ========================================================
   logic [3:0] idx_q;
   logic [3:0] idx_d;
   always_comb begin
      idx_d = idx_q;
      if (out_valid_q && out_ready) begin
         idx_d = out_last_q ? 4'h0 : idx_q + 4'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      idx_q <= rst ? 4'h0 : idx_d;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_take;
      req_valid && req_ready_q;
   endsequence
   sequence s_take_bytes;
      s_take ##0 (req_len != 8'h00);
   endsequence

   a_ready_drop: assert property (s_take_bytes |=> !req_ready_q)
      else $error("ready stayed high after a request");
   a_empty_done: assert property (s_take ##0 (req_len == 8'h00) |=> done_q && req_ready_q)
      else $error("empty request not finished at once");
   // a zero-length request taken while done is up legally re-pulses done
   a_done_pulse: assert property (done_q && !(req_valid && req_ready_q && req_len == 8'h00)
      |=> !done_q)
      else $error("done longer than one cycle");
   a_ready_rise: assert property ($rose(req_ready_q) |-> done_q)
      else $error("ready back without done");
   a_done_bound: assert property (s_take_bytes |-> ##[1:1000] done_q)
      else $error("request never finished");
   a_stream_hold: assert property (out_valid_q && !out_ready |=>
      out_valid_q && $stable(out_data_q) && $stable(out_last_q))
      else $error("byte changed before taken");
   a_first_len: assert property (out_valid_q && idx_q == 4'h0 |->
      out_data_q == 8'h07 || out_data_q == 8'h09)
      else $error("bad descriptor length byte");
   a_offset_four: assert property (out_valid_q && idx_q == 4'h4 |-> out_data_q == 8'h01)
      else $error("bad byte at offset four");
   a_offset_seven: assert property (out_valid_q && idx_q == 4'h7 |->
      out_data_q inside {8'h01, 8'h02, 8'hA0, 8'hE0})
      else $error("bad byte at offset seven");
   a_ninth_last: assert property (out_valid_q && idx_q == 4'h8 |-> out_last_q)
      else $error("ninth byte not last");
endmodule

bind hdg_gen hdg_gen_asserts hdg_gen_asserts_inst (.ref_clk(ref_clk), .rst(rst),
   .req_valid(req_valid), .req_len(req_len), .req_ready_q(req_ready_q), .done_q(done_q),
   .out_valid_q(out_valid_q), .out_data_q(out_data_q), .out_last_q(out_last_q),
   .out_ready(out_ready));

// >>> hdg_host_sink.sv
// host side of the descriptor stream: takes bytes and keeps them
// assumes pacing inputs from the bench, driven just after the edge
`timescale 1ns/1ps
module hdg_host_sink (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // stream from the generator
   input wire logic out_valid_q,
   input wire logic [7:0] out_data_q,
   input wire logic out_last_q,
   output logic out_ready,
   // pacing from the bench
   input wire logic hold,
   input wire logic jitter
);
   logic [8:0] got_q[$];
   initial out_ready = 1'b0;
   // a host pauses between bytes, so the generator must hold its byte
   always @(posedge ref_clk) begin
      if (!rst && out_valid_q && out_ready) begin
         got_q.push_back({out_last_q, out_data_q});
      end
      out_ready <= #1 !rst && !hold && jitter;
   end
endmodule

// >>> hub_descriptor_generator_test.sv
// bench for the hub descriptor generator: reference model and host sink
// assumes the checker is bound in and the design top is hdg_gen
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module hub_descriptor_generator_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic sel = 1'b0;
   logic [7:0] bl = 8'h00;
   logic [7:0] sl = 8'h00;
   logic req_valid = 1'b0;
   logic [1:0] req_kind = 2'h0;
   logic [7:0] req_len = 8'h00;
   logic hold = 1'b0;
   logic jitter = 1'b1;
   logic req_ready_q, done_q, out_valid_q, out_last_q, out_ready;
   logic [7:0] out_data_q;
   logic [31:0] seed = 32'hcb11_812d;
   logic [8:0] exp_q[$];
   int mismatches = 0;
   int cmp_count = 0;
   int lens[6] = '{255, 255, 0, 1, 6, 8};

   hdg_gen hdg_gen_inst (.ref_clk(ref_clk), .rst(rst), .power_source_select(sel),
      .bus_powered_current_limit(bl), .self_powered_current_limit(sl),
      .req_valid(req_valid), .req_kind(req_kind), .req_len(req_len),
      .req_ready_q(req_ready_q), .done_q(done_q), .out_valid_q(out_valid_q),
      .out_data_q(out_data_q), .out_last_q(out_last_q), .out_ready(out_ready));
   hdg_host_sink hdg_host_sink_inst (.ref_clk(ref_clk), .rst(rst), .out_valid_q(out_valid_q),
      .out_data_q(out_data_q), .out_last_q(out_last_q), .out_ready(out_ready),
      .hold(hold), .jitter(jitter));

   always #5 ref_clk = ~ref_clk;

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // ========================================================
   // reference model: descriptor bytes in ascending offset
   // ========================================================
   function automatic logic [7:0] exp_byte(int k, int i, logic s, logic [7:0] b, logic [7:0] p);
      logic [71:0] v;
      case (k)
         0: v = {8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C, 16'h0000};
         1: v = {8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h01, 8'h00};
         2: v = {8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'h09, 8'h00, 8'h02, 8'h00};
         default: v = {8'h09, 8'h07, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 16'h0000};
      endcase
      if (k == 3) v[15:0] = {s ? 8'hE0 : 8'hA0, s ? p : b};
      return v[71 - 8 * i -: 8];
   endfunction

   task end_of_test();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task fail(string m);
      mismatches++;
      $display("ERROR %0t: %s", $time, m);
      end_of_test();
   endtask

   always @(posedge ref_clk) begin
      #1;
      jitter = (rnd() & 32'h0000_0003) != 32'h0000_0000;
   end

   // power inputs are scrambled right after the take: the answer must not follow them
   task send(int k, int len);
      int d, n, t, i;
      d = (k == 0) ? 7 : 9;
      n = (len < d) ? len : d;
      req_kind = k[1:0];
      req_len = len[7:0];
      req_valid = 1'b1;
      for (t = 0; t < 100 && req_ready_q !== 1'b1; t++) @(posedge ref_clk) #1;
      if (t == 100) fail("request not taken");
      for (i = 0; i < n; i++) exp_q.push_back({i == n - 1, exp_byte(k, i, sel, bl, sl)});
      @(posedge ref_clk) #1;
      {sel, bl, sl} = 17'(rnd());
      if (len == 0) begin
         req_valid = 1'b0;
      end else begin
         req_kind = ~k[1:0];
         @(posedge ref_clk) #1;
         req_valid = 1'b0;
      end
      for (t = 0; t < 1000 && done_q !== 1'b1; t++) begin
         if (t == 40) hold = 1'b0;
         @(posedge ref_clk) #1;
      end
      if (t == 1000) fail("request never done");
      @(posedge ref_clk) #1;
   endtask

   task check_stream();
      int t;
      logic [8:0] g;
      logic [8:0] x;
      for (t = 0; t < 2000 && hdg_host_sink_inst.got_q.size() < exp_q.size(); t++) begin
         @(posedge ref_clk);
      end
      if (t == 2000) fail("stream stalled");
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(hdg_host_sink_inst.got_q.size(), exp_q.size())
      while (exp_q.size() > 0 && hdg_host_sink_inst.got_q.size() > 0) begin
         g = hdg_host_sink_inst.got_q.pop_front();
         x = exp_q.pop_front();
         `CHK(g, x)
      end
      exp_q.delete();
      hdg_host_sink_inst.got_q.delete();
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      // kinds cycle fastest; power mode and host byte limit both step every four requests
      for (int r = 0; r < 24; r++) begin
         {bl, sl} = 16'(rnd());
         sel = 1'((r / 4) % 2);
         hold = (r == 1 || r == 2);
         send(r % 4, lens[r / 4]);
         if (!hold) check_stream();
      end
      end_of_test();
   end
endmodule
